// ==== design/spi_frame_pkg.sv ====
// package: constants and types for the spi command-frame layer
`default_nettype none
package spi_frame_pkg;
    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int FRAME_W     = 16;
    localparam int MIN_CLOCKS  = 16;
    localparam int MAX_EXTRA   = 2;
    localparam int BYTE_BITS   = 8;
    localparam int CNT_W       = 6;
    localparam int OP_HI       = 15;
    localparam int OP_LO       = 14;
    localparam int PRI_HI      = 13;
    localparam int PRI_LO      = 10;
    localparam int SEC_HI      = 9;
    localparam int SEC_LO      = 8;
    localparam int TER_BIT     = 10;
    localparam int TAIL_HI     = 1;
    // ------------------------------------------------------------
    // opcodes in the two leading bits, plus the read tail and the echo tag
    // ------------------------------------------------------------
    localparam logic [1:0] OP_WRITE     = 2'h2;
    localparam logic [1:0] OP_READ      = 2'h1;
    localparam logic [1:0] OP_BAD_WRITE = 2'h3;
    localparam logic [1:0] OP_BAD_READ  = 2'h0;
    localparam logic [1:0] TAIL_WIDE    = 2'h2;
    localparam logic [1:0] ECHO_TAG     = 2'h2;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] DIAG_RESET  = 16'h7800;
    localparam logic [15:0] INSTR_RESET = 16'h0000;
    localparam logic [15:0] SYNTAX_REPLY_BASE = 16'h0000;

    typedef enum logic [1:0] {
        REPLY_DIAG   = 2'b00,
        REPLY_ECHO   = 2'b01,
        REPLY_RESET  = 2'b10,
        REPLY_SYNTAX = 2'b11
    } reply_kind_t;

    typedef struct packed {
        logic        wide;
        logic [3:0]  primary_register_address;
        logic [1:0]  secondary_register_address;
        logic [9:0]  content;
    } reg_access_t;
endpackage
`default_nettype wire

// ==== design/spi_frame_slave.sv ====
// design: command-frame layer of the 16-bit spi slave
`default_nettype none
module spi_frame_slave
    import spi_frame_pkg::*;
#(
    parameter logic [15:0] VALID_PRIMARY = 16'h00ff,
    parameter logic [15:0] WIDE_PRIMARY  = 16'h000f
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        soft_reset,
    input  wire logic        serial_clock,
    input  wire logic        chip_select_low_active,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             serial_out_en,
    input  wire logic [15:0] diag_status,
    input  wire logic [15:0] instruction_register,
    input  wire logic [9:0]  read_content,
    output reg_access_t      read_addr,
    output reg_access_t      write_req,
    output logic             write_strobe
);
    // ------------------------------------------------------------
    // pin synchronisers; first stage feeds only the second
    // ------------------------------------------------------------
    logic [1:0] sclk_sync, cs_sync, si_sync;
    logic       sclk_q, cs_q;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_sync <= 2'h0;
            cs_sync   <= 2'h3;
            si_sync   <= 2'h0;
            sclk_q    <= 1'b0;
            cs_q      <= 1'b1;
        end else begin
            sclk_sync <= {sclk_sync[0], serial_clock};
            cs_sync   <= {cs_sync[0], chip_select_low_active};
            si_sync   <= {si_sync[0], serial_in};
            sclk_q    <= sclk_sync[1];
            cs_q      <= cs_sync[1];
        end
    end

    wire selected  = !cs_sync[1];
    wire sclk_rise = sclk_sync[1] && !sclk_q && selected;
    wire sclk_fall = !sclk_sync[1] && sclk_q && selected;
    wire cs_fall   = !cs_sync[1] && cs_q;
    wire cs_rise   = cs_sync[1] && !cs_q;

    // ------------------------------------------------------------
    // shift path
    // ------------------------------------------------------------
    logic [FRAME_W-1:0] rx_shift, tx_shift, reply;
    logic [CNT_W-1:0]   clk_count;
    logic               ter_flag, reset_pending;

    // sample on rising, drive on falling: data held through the edge
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_shift  <= '0;
            tx_shift  <= '0;
            clk_count <= '0;
        end else if (cs_fall) begin
            tx_shift  <= reply;
            clk_count <= '0;
        end else if (sclk_rise) begin
            rx_shift  <= {rx_shift[FRAME_W-2:0], si_sync[1]};
            clk_count <= (clk_count == '1) ? clk_count
                         : clk_count + CNT_W'(1);
        end else if (sclk_fall) begin
            tx_shift  <= {tx_shift[FRAME_W-2:0], rx_shift[0]};
        end
    end
    assign serial_out    = tx_shift[FRAME_W-1];
    assign serial_out_en = selected;

    // ------------------------------------------------------------
    // frame decode at chip-select release
    // ------------------------------------------------------------
    // longer daisy frames keep the last sixteen bits in the register
    wire [1:0] opcode  = rx_shift[OP_HI:OP_LO];
    wire [3:0] primary = rx_shift[PRI_HI:PRI_LO];
    wire       wide    = WIDE_PRIMARY[primary];
    wire len_ok = (clk_count[2:0] == 3'h0)
               && (clk_count >= CNT_W'(MIN_CLOCKS))
               && (clk_count <= CNT_W'(MIN_CLOCKS + MAX_EXTRA * BYTE_BITS));
    wire reserved = !VALID_PRIMARY[primary];
    wire is_write = opcode == OP_WRITE;
    wire is_read  = (opcode == OP_READ)
                 && (rx_shift[TAIL_HI:0] == TAIL_WIDE);
    wire diag_read = (opcode == OP_READ) && !is_read;
    wire syntax_err = (opcode == OP_BAD_WRITE)
                   || (opcode == OP_BAD_READ)
                   || ((is_write || is_read) && reserved);
    wire frame_done = cs_rise;
    wire accept     = frame_done && len_ok && !syntax_err;

    reply_kind_t kind;
    reg_access_t echo;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            kind          <= REPLY_RESET;
            ter_flag      <= 1'b1;
            reset_pending <= 1'b1;
            echo          <= '0;
        end else if (soft_reset) begin
            kind          <= REPLY_RESET;
            ter_flag      <= 1'b1;
            reset_pending <= 1'b1;
        end else if (frame_done) begin
            reset_pending <= 1'b0;
            ter_flag      <= !len_ok;
            if (!len_ok)
                kind <= REPLY_DIAG;
            else if (syntax_err)
                kind <= REPLY_SYNTAX;
            else if (is_read) begin
                kind <= REPLY_ECHO;
                echo <= '{wide, primary, rx_shift[SEC_HI:SEC_LO],
                          read_content};
            end else
                kind <= REPLY_DIAG;
        end
    end

    // ------------------------------------------------------------
    // reply selection
    // ------------------------------------------------------------
    wire [15:0] diag_word = {1'b0, diag_status[14:11], ter_flag,
                             diag_status[9:0]};
    wire [15:0] echo_word = echo.wide
        ? {ECHO_TAG, echo.primary_register_address, echo.content}
        : {ECHO_TAG, echo.primary_register_address,
           echo.secondary_register_address, echo.content[7:0]};
    always_comb begin
        case (kind)
            REPLY_RESET:  reply = {instruction_register[15:11], 1'b1,
                                   instruction_register[9:0]};
            REPLY_ECHO:   reply = echo_word;
            REPLY_SYNTAX: reply = SYNTAX_REPLY_BASE | diag_word;
            REPLY_DIAG:   reply = diag_word;
            default:      reply = diag_word;
        endcase
    end

    // ------------------------------------------------------------
    // register access outputs
    // ------------------------------------------------------------
    assign read_addr = '{wide, primary, rx_shift[SEC_HI:SEC_LO], 10'h000};
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            write_req    <= '0;
            write_strobe <= 1'b0;
        end else begin
            write_strobe <= accept && is_write;
            if (accept && is_write)
                write_req <= '{wide, primary,
                               rx_shift[SEC_HI:SEC_LO],
                               wide ? rx_shift[9:0]
                                    : {2'h0, rx_shift[7:0]}};
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_NO_WRITE_ON_ERROR: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        frame_done && (!len_ok || syntax_err) |=> !write_strobe)
        else $error("write after errored frame");
    AST_TER_ON_BAD_LEN: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        frame_done && !len_ok && !soft_reset |=> ter_flag)
        else $error("length error not flagged");
    AST_TER_CLEAR: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        frame_done && len_ok && !soft_reset |=> !ter_flag)
        else $error("flag not cleared");
    AST_RESET_REPLY: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        soft_reset |=> kind == REPLY_RESET && reply[TER_BIT])
        else $error("reset reply missing");
    AST_SYNTAX: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        frame_done && len_ok && opcode == OP_BAD_WRITE && !soft_reset
        |=> kind == REPLY_SYNTAX)
        else $error("syntax error missed");
    AST_ECHO: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        kind == REPLY_ECHO |-> reply[OP_HI:OP_LO] == ECHO_TAG)
        else $error("echo tag wrong");
    AST_LOAD_ON_CS: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        cs_fall |=> tx_shift == $past(reply))
        else $error("reply not loaded");
    AST_DIAG_TOP: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        kind == REPLY_DIAG |-> !reply[OP_HI])
        else $error("diagnosis top bit set");
    AST_SYNTAX_READ: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        frame_done && len_ok && opcode == OP_BAD_READ && !soft_reset
        |=> kind == REPLY_SYNTAX)
        else $error("read syntax error missed");
    // pending reset means the next loaded reply carries the flag
    AST_RESET_FIRST: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        cs_fall && reset_pending && !soft_reset |=> tx_shift[TER_BIT])
        else $error("first reply lacks flag");
    AST_DIAG_READ: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        frame_done && len_ok && diag_read && !soft_reset
        |=> kind == REPLY_DIAG)
        else $error("diagnosis read not answered");
endmodule
`default_nettype wire

// ==== dv/spi_frame_slave_tb.sv ====
// self-checking bench for the spi command-frame layer
`default_nettype none
module spi_frame_slave_tb
    import spi_frame_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // bench
    // ------------------------------------------------------------
    localparam logic [15:0] VP = 16'h00ff;
    localparam logic [15:0] WP = 16'h000f;
    logic        core_clk, reset_n, soft_reset, serial_out_en;
    logic        serial_clock, chip_select_low_active, serial_in;
    logic        serial_out, write_strobe, pt;
    logic [15:0] diag_status, instruction_register, rx, pf;
    logic [9:0]  read_content, prc;
    reg_access_t read_addr, write_req;
    reply_kind_t pk;
    logic [31:0] lfsr;
    int          errors, num_checks;
    int          strobes = 0;
    int          en_hi = 0;
    logic [39:0] ctx [13] = '{40'h83ff, 40'h4002, 40'h5a96a5, 40'h5602,
        40'hc123, 40'h0002, 40'ha400, 40'h7002,
        40'h8001, 40'h1234_5680_55, 40'h80, 40'h4001, 40'h8155};
    int          cn [13] = '{16, 16, 24, 32, 16, 16, 16, 16, 15, 40, 8, 17, 16};
    int          ln [6] = '{16, 16, 24, 32, 17, 40};

    spi_frame_slave #(
        .VALID_PRIMARY(VP),
        .WIDE_PRIMARY (WP)
    ) uut (
        .core_clk              (core_clk),
        .reset_n               (reset_n),
        .soft_reset            (soft_reset),
        .serial_clock          (serial_clock),
        .chip_select_low_active(chip_select_low_active),
        .serial_in             (serial_in),
        .serial_out            (serial_out),
        .serial_out_en         (serial_out_en),
        .diag_status           (diag_status),
        .instruction_register  (instruction_register),
        .read_content          (read_content),
        .read_addr             (read_addr),
        .write_req             (write_req),
        .write_strobe          (write_strobe)
    );
    spi_host_model host (
        .core_clk              (core_clk),
        .serial_clock          (serial_clock),
        .chip_select_low_active(chip_select_low_active),
        .serial_in             (serial_in),
        .serial_out            (serial_out)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
        if (write_strobe === 1'b1)
            strobes++;
    // cycles with the output driven, to see it enabled inside a frame
    always @(posedge core_clk)
        if (serial_out_en === 1'b1)
            en_hi++;
    function automatic logic [31:0] step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // owed reply worked out from the previous frame
    function automatic logic [15:0] want(logic [15:0] d);
        logic [3:0] a;
        a = pf[13:10];
        case (pk)
            REPLY_RESET: return instruction_register | 16'h0400;
            REPLY_ECHO: return WP[a] ? {2'h2, a, prc}
                                      : {2'h2, pf[13:8], prc[7:0]};
            default: return {1'b0, d[14:11], pt, d[9:0]};
        endcase
    endfunction
    task automatic cmp(input logic [15:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic run(input logic [39:0] tx, input int n);
        logic [15:0] f;
        logic [1:0]  op;
        logic        good, ok, wr;
        logic [15:0] wa, ra;
        logic [9:0]  wc;
        int          s0, e0;
        f = tx[15:0];
        op = f[15:14];
        lfsr = step(lfsr);
        @(posedge core_clk);
        diag_status <= lfsr[15:0];
        read_content <= lfsr[25:16];
        instruction_register <= lfsr[31:16];
        s0 = strobes;
        e0 = en_hi;
        @(posedge core_clk);
        host.xfer(tx, n, rx);
        // short frames cannot carry a whole reply
        if (n >= 16)
            cmp(rx, want(diag_status));
        cmp({14'h0, en_hi > e0, serial_out_en}, 16'h0002);
        ra = {9'h0, read_addr.wide, read_addr.primary_register_address,
              read_addr.secondary_register_address};
        if (n >= 16)
            cmp(ra, {9'h0, WP[f[13:10]], f[13:8]});
        good = n >= 16 && n % 8 == 0 && n <= 32;
        ok = VP[f[13:10]];
        wr = good && ok && op == OP_WRITE;
        cmp(16'(strobes - s0), {15'h0, wr});
        if (wr) begin
            wa = {11'h0, write_req.wide, write_req.primary_register_address};
            wc = write_req.wide ? write_req.content
                 : {write_req.secondary_register_address,
                    write_req.content[7:0]};
            cmp(wa, {11'h0, WP[f[13:10]], f[13:10]});
            cmp({6'h0, wc}, {6'h0, f[9:0]});
        end
        // host keeps what it sent to read the next reply
        pt = !good;
        if (!good || op == OP_READ && f[1:0] != TAIL_WIDE)
            pk = REPLY_DIAG;
        else if (!ok || op == OP_BAD_WRITE || op == OP_BAD_READ)
            pk = REPLY_SYNTAX;
        else
            pk = op == OP_READ ? REPLY_ECHO : REPLY_DIAG;
        pf = f;
        prc = read_content;
    endtask
    initial begin
        reset_n = 1'b0;
        soft_reset = 1'b0;
        errors = 0;
        num_checks = 0;
        lfsr = 32'h2365;
        diag_status = 16'h0000;
        read_content = 10'h000;
        instruction_register = 16'h3a5c;
        pk = REPLY_RESET;
        pt = 1'b1;
        pf = 16'h0000;
        prc = 10'h000;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        foreach (ctx[i])
            run(ctx[i], cn[i]);
        $display("corner frames done");
        @(posedge core_clk);
        soft_reset <= 1'b1;
        @(posedge core_clk);
        soft_reset <= 1'b0;
        pk = REPLY_RESET;
        run(40'h8200, 16);
        $display("soft reset done");
        for (int i = 0; i < 60; i++) begin
            lfsr = step(lfsr);
            run({lfsr[7:0], lfsr}, ln[int'(lfsr[18:16]) % 6]);
        end
        $display("random frames done");
        end_sim();
    end
    // about 1.6 times the longest possible run
    initial begin
        repeat (90000) @(posedge core_clk);
        errors++;
        end_sim();
    end
endmodule
`default_nettype wire

// ==== dv/spi_host_model.sv ====
// host spi master model that shifts frames into the slave
`default_nettype none
module spi_host_model (
    input  wire logic        core_clk,
    output logic             serial_clock,
    output logic             chip_select_low_active,
    output logic             serial_in,
    input  wire logic        serial_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // frame driver
    // ------------------------------------------------------------
    // clock idles low between frames, no free-running clock
    initial begin
        serial_clock = 1'b0;
        chip_select_low_active = 1'b1;
        serial_in = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // msb first, one bit per clock
    // read frames end in the tail
    task automatic xfer(input logic [39:0] tx, input int n,
                        output logic [15:0] rx);
        rx = 16'h0000;
        wt(1);
        chip_select_low_active <= 1'b0;
        wt(10);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= tx[i];
            wt(10);
            serial_clock <= 1'b1;
            wt(1);
            if (i >= n - 16)
                rx = {rx[14:0], serial_out};
            wt(9);
            serial_clock <= 1'b0;
        end
        wt(10);
        // frame ends on cs rise
        chip_select_low_active <= 1'b1;
        // released line must not keep the last bit
        serial_in <= ~serial_in;
        wt(20);
    endtask
endmodule
`default_nettype wire
